// >>> msg_register_map_map.svh
/*
  offsets, field positions, reset values, command codes and frame counts
  of the serially programmed mux register map. definitions only.
*/
`ifndef MSG_REGISTER_MAP_MAP_SVH
`define MSG_REGISTER_MAP_MAP_SVH

// ==================================================================
// register offsets
`define MSG_OFS_SWITCH        7'h01
`define MSG_OFS_ERR_ENABLE    7'h02
`define MSG_OFS_ERR_FLAGS     7'h03
`define MSG_OFS_CONSEC        7'h05
`define MSG_OFS_CYCLE_EN      7'h06
`define MSG_OFS_CYCLE_SEL     7'h07
`define MSG_OFS_EDGE          7'h09
`define MSG_OFS_RESTART       7'h0b

// ==================================================================
// reset values
`define MSG_RST_SWITCH        8'h00
`define MSG_RST_ERR_ENABLE    3'h6
`define MSG_RST_CYCLE_SEL8    8'hff
`define MSG_RST_CYCLE_SEL4    8'h0f

// ==================================================================
// field positions
`define MSG_BIT_MUX_EN        0
`define MSG_BIT_ADDR_EN       2
`define MSG_BIT_COUNT_EN      1
`define MSG_BIT_CRC_EN        0
`define MSG_BIT_RW            15

// ==================================================================
// commands and frame counts
`define MSG_CMD_CLEAR         16'h6ca9
`define MSG_CLEAR_FIRST       8'h6c
`define MSG_CMD_EXIT_A        16'ha318
`define MSG_CMD_EXIT_B        16'he3b4
`define MSG_KEY_FIRST         8'ha3
`define MSG_KEY_SECOND        8'h05
`define MSG_CRC_POLY          8'h07
`define MSG_LEN_PLAIN         5'd16
`define MSG_LEN_CRC           5'd24
`define MSG_POS_ADDR          5'd8

`endif

// >>> msg_pkg.sv
/*
  types of the mux register map.
  assumes msg_register_map_map.svh holds the numeric constants.
*/
package msg_pkg;
  typedef enum logic [2:0] {
    MODE_ADDR  = 3'b001,
    MODE_CYCLE = 3'b010,
    MODE_EXIT  = 3'b100
  } msg_mode_type;
endpackage : msg_pkg

// >>> msg_register_map.sv
/*
  register map of a serially programmed analog mux with general outputs,
  reached over a four-wire serial slave link (mode 0, msb first).
  assumes cs_n, sclk, sdi and convert_trigger_pin are asynchronous pins,
  and clk runs well above four times the serial clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msg_register_map_map.svh"

module msg_register_map #(
  parameter bit DUAL_VARIANT = 1'b0                 // 1 = dual 4:1 variant
) (
  input  wire logic       clk,                      // 200 mhz clock
  input  wire logic       reset_n,                  // synchronous reset
  input  wire logic       cs_n,                     // serial chip select
  input  wire logic       sclk,                     // serial clock pin
  input  wire logic       sdi,                      // serial data in
  input  wire logic       convert_trigger_pin,      // cycling step pin
  output logic            sdo,                      // serial data out
  output logic [4:0]      general_output,           // general outputs
  output logic [2:0]      channel_select,           // switch address
  output logic            mux_enable                // mux on
);

  // ================================================================
  // pin synchronisers
  logic [2:0] cs_s_q, sclk_s_q, cnv_s_q;
  logic [1:0] sdi_s_q;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cs_s_q   <= 3'h7;
      sclk_s_q <= 3'h0;
      cnv_s_q  <= 3'h0;
      sdi_s_q  <= 2'h0;
    end
    else
    begin
      cs_s_q   <= {cs_s_q[1:0], cs_n};
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      cnv_s_q  <= {cnv_s_q[1:0], convert_trigger_pin};
      sdi_s_q  <= {sdi_s_q[0], sdi};
    end
  end

  wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2] & ~cs_s_q[1];
  wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2] & ~cs_s_q[1];
  wire cs_fall   = ~cs_s_q[1] & cs_s_q[2];
  wire cs_rise   = cs_s_q[1] & ~cs_s_q[2];
  wire sdi_bit   = sdi_s_q[1];

  // ================================================================
  // registers
  logic [7:0]          sw_q, cyc_sel_q, key_q;
  logic [2:0]          err_en_q, flags_q;
  logic                consec_q, cyc_en_q, edge_q;
  msg_pkg::msg_mode_type mode_q;
  logic                soft_q, armed_q;

  // ================================================================
  // frame shifter
  logic [23:0] shift_q;
  logic [4:0]  pos_q;
  logic        over_q, bad_addr_q;
  logic [7:0]  crc_q, rd_sh_q;
  logic        sdo_q;

  wire        crc_on    = err_en_q[`MSG_BIT_CRC_EN];
  wire [4:0]  frame_len = crc_on ? `MSG_LEN_CRC : `MSG_LEN_PLAIN;
  wire        cycling   = (mode_q != msg_pkg::MODE_ADDR);
  wire [23:0] shift_nx  = {shift_q[22:0], sdi_bit};
  wire [4:0]  pos_nx    = pos_q + 5'd1;
  wire        counting  = sclk_rise & (pos_q != frame_len);
  wire        addr_edge = counting & (pos_nx == `MSG_POS_ADDR);
  wire        done      = counting & (pos_nx == frame_len);
  wire [15:0] cmd       = crc_on ? shift_nx[23:8] : shift_nx[15:0];
  wire [6:0]  addr_nx   = shift_nx[6:0];
  wire        rd_nx     = shift_nx[7];

  // address byte check, the clear command itself is exempt
  wire addr_known = (addr_nx == `MSG_OFS_SWITCH) | (addr_nx == `MSG_OFS_ERR_ENABLE)
                  | (addr_nx == `MSG_OFS_ERR_FLAGS) | (addr_nx == `MSG_OFS_CONSEC)
                  | (addr_nx == `MSG_OFS_CYCLE_EN) | (addr_nx == `MSG_OFS_CYCLE_SEL)
                  | (addr_nx == `MSG_OFS_EDGE) | (addr_nx == `MSG_OFS_RESTART);
  wire addr_clear = (shift_nx[7:0] == `MSG_CLEAR_FIRST);
  wire addr_bad   = err_en_q[`MSG_BIT_ADDR_EN] & ~addr_clear & ~cycling
                  & (~addr_known | (~rd_nx & (addr_nx == `MSG_OFS_ERR_FLAGS)));

  // serial crc over the command bits
  wire       crc_fb  = crc_q[7] ^ sdi_bit;
  wire [7:0] crc_nx  = {crc_q[6:0], 1'b0} ^ (crc_fb ? `MSG_CRC_POLY : 8'h00);
  wire       crc_ok  = ~crc_on | (crc_q == shift_nx[7:0]);

  // command outcome
  wire       is_clear  = (cmd == `MSG_CMD_CLEAR);
  wire       clear_go  = done & crc_ok & is_clear & ~cycling;
  wire       wr_go     = done & crc_ok & ~bad_addr_q & ~cmd[`MSG_BIT_RW]
                       & ~is_clear & ~cycling;
  wire [6:0] wr_addr   = cmd[14:8];
  wire [7:0] wr_data   = cmd[7:0];
  wire       wr_switch = wr_go & (wr_addr == `MSG_OFS_SWITCH);
  wire       wr_key    = wr_go & (wr_addr == `MSG_OFS_RESTART);
  wire       key_done  = wr_key & armed_q & (wr_data == `MSG_KEY_SECOND);
  wire       exit_a    = done & crc_ok & mode_q == msg_pkg::MODE_CYCLE
                       & (cmd == `MSG_CMD_EXIT_A);
  wire       exit_b    = done & crc_ok & (mode_q == msg_pkg::MODE_EXIT)
                       & (cmd == `MSG_CMD_EXIT_B);

  // count check when the frame closes
  wire count_bad = consec_q ? ((pos_q != 5'd0) | over_q)
                            : ((pos_q != frame_len) | over_q);
  wire count_err = cs_rise & err_en_q[`MSG_BIT_COUNT_EN] & ~cycling & count_bad;

  // read data chosen at the address edge
  logic [7:0] rd_data;
  always_comb
  begin
    case (addr_nx)
      `MSG_OFS_SWITCH:     rd_data = sw_q;
      `MSG_OFS_ERR_ENABLE: rd_data = {5'h00, err_en_q};
      `MSG_OFS_ERR_FLAGS:  rd_data = {5'h00, flags_q};
      `MSG_OFS_CONSEC:     rd_data = {7'h00, consec_q};
      `MSG_OFS_CYCLE_EN:   rd_data = {7'h00, cyc_en_q};
      `MSG_OFS_CYCLE_SEL:  rd_data = cyc_sel_q;
      `MSG_OFS_EDGE:       rd_data = {7'h00, edge_q};
      `MSG_OFS_RESTART:    rd_data = key_q;
      default:             rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n || cs_fall)
    begin
      shift_q    <= 24'h000000;
      pos_q      <= 5'd0;
      over_q     <= 1'b0;
      bad_addr_q <= 1'b0;
      crc_q      <= 8'h00;
    end
    else if (sclk_rise)
    begin
      shift_q <= shift_nx;
      if (pos_q == frame_len)
        over_q <= 1'b1;
      else if (done && consec_q)
        pos_q <= 5'd0;
      else
        pos_q <= pos_nx;
      if (addr_edge)
        bad_addr_q <= addr_bad;
      else if (done)
        bad_addr_q <= 1'b0;
      if (done)
        crc_q <= 8'h00;
      else if (pos_q < `MSG_LEN_PLAIN)
        crc_q <= crc_nx;
    end
  end

  // data out changes on the falling serial edge
  always_ff @(posedge clk)
  begin
    if (!reset_n || cs_fall)
    begin
      rd_sh_q <= 8'h00;
      sdo_q   <= 1'b0;
    end
    else if (addr_edge)
      rd_sh_q <= rd_nx ? rd_data : 8'h00;
    else if (sclk_fall)
    begin
      sdo_q   <= rd_sh_q[7];
      rd_sh_q <= {rd_sh_q[6:0], 1'b0};
    end
  end

  assign sdo = sdo_q;

  // ================================================================
  // register file
  wire [7:0] sel_rst = DUAL_VARIANT ? `MSG_RST_CYCLE_SEL4 : `MSG_RST_CYCLE_SEL8;
  wire [2:0] flag_set = {addr_edge & addr_bad, count_err, done & ~crc_ok};

  always_ff @(posedge clk)
  begin
    if (!reset_n || soft_q)
    begin
      sw_q      <= `MSG_RST_SWITCH;
      err_en_q  <= `MSG_RST_ERR_ENABLE;
      consec_q  <= 1'b0;
      cyc_en_q  <= 1'b0;
      cyc_sel_q <= sel_rst;
      edge_q    <= 1'b0;
      key_q     <= 8'h00;
      flags_q   <= 3'h0;
    end
    else
    begin
      if (wr_switch)
        sw_q <= wr_data;
      if (wr_go && wr_addr == `MSG_OFS_ERR_ENABLE)
        err_en_q <= wr_data[2:0];
      if (wr_go && wr_addr == `MSG_OFS_CONSEC)
        consec_q <= wr_data[0];
      if (wr_go && wr_addr == `MSG_OFS_CYCLE_EN)
        cyc_en_q <= wr_data[0];
      else if (exit_b)
        cyc_en_q <= 1'b0;
      if (wr_go && wr_addr == `MSG_OFS_CYCLE_SEL)
        cyc_sel_q <= wr_data & sel_rst;
      if (wr_go && wr_addr == `MSG_OFS_EDGE)
        edge_q <= wr_data[0];
      if (wr_key)
        key_q <= wr_data;
      // a new error in the clearing cycle survives
      flags_q <= (clear_go ? 3'h0 : flags_q) | flag_set;
    end
  end

  // two-step restart key and channel cycling mode
  always_ff @(posedge clk)
  begin
    if (!reset_n || soft_q)
    begin
      soft_q  <= 1'b0;
      armed_q <= 1'b0;
      mode_q  <= msg_pkg::MODE_ADDR;
    end
    else
    begin
      soft_q <= key_done;
      if (done)
        armed_q <= wr_key & (wr_data == `MSG_KEY_FIRST);
      case (mode_q)
        msg_pkg::MODE_ADDR:
          if (cyc_en_q)
            mode_q <= msg_pkg::MODE_CYCLE;
        msg_pkg::MODE_CYCLE:
          if (exit_a)
            mode_q <= msg_pkg::MODE_EXIT;
        msg_pkg::MODE_EXIT:
          if (exit_b)
            mode_q <= msg_pkg::MODE_ADDR;
          else if (done)
            mode_q <= msg_pkg::MODE_CYCLE;
        default:
          mode_q <= msg_pkg::MODE_ADDR;
      endcase
    end
  end

  // ================================================================
  // channel stepping on the convert pin
  function automatic logic [2:0] next_chan(input logic [2:0] idx, input logic [7:0] mask);
    logic [2:0] res;
    logic       found;
    logic [2:0] cand;
    res   = idx;
    found = 1'b0;
    for (int k = 1; k <= 8; k++)
    begin
      cand = idx + 3'(k);
      if (DUAL_VARIANT)
        cand = {1'b0, cand[1:0]};
      if (!found && mask[cand])
      begin
        res   = cand;
        found = 1'b1;
      end
    end
    return res;
  endfunction : next_chan

  logic [2:0] cyc_idx_q;
  wire cnv_edge = ~cs_s_q[1] & (edge_q ? (~cnv_s_q[1] & cnv_s_q[2])
                                       : (cnv_s_q[1] & ~cnv_s_q[2]));
  wire [2:0] last_idx = DUAL_VARIANT ? 3'd3 : 3'd7;

  always_ff @(posedge clk)
  begin
    if (!reset_n || soft_q)
      cyc_idx_q <= 3'd0;
    else if (!cycling)
      cyc_idx_q <= next_chan(last_idx, cyc_sel_q);
    else if (cnv_edge)
      cyc_idx_q <= next_chan(cyc_idx_q, cyc_sel_q);
  end

  // ================================================================
  // output pins, all loaded in one edge
  wire [4:0] gpo_from_sw  = DUAL_VARIANT ? sw_q[7:3] : {1'b0, sw_q[7:4]};
  wire [2:0] chan_from_sw = DUAL_VARIANT ? {1'b0, sw_q[2:1]} : sw_q[3:1];
  logic [4:0] gpo_q;
  logic [2:0] chan_q;
  logic       en_q;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      gpo_q  <= 5'h00;
      chan_q <= 3'd0;
      en_q   <= 1'b0;
    end
    else
    begin
      gpo_q  <= cycling ? 5'h00 : gpo_from_sw;
      chan_q <= cycling ? cyc_idx_q : chan_from_sw;
      en_q   <= cycling ? (cyc_sel_q != 8'h00) : sw_q[`MSG_BIT_MUX_EN];
    end
  end

  assign general_output = gpo_q;
  assign channel_select = chan_q;
  assign mux_enable     = en_q;

  // ================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_switch_write;
    wr_switch & ~cycling ##1 ~cycling & ~soft_q;
  endsequence

  a_gpo_forced_low: assert property (cycling |=> gpo_q == 5'h00)
    else $error("general outputs not low in cycling mode");
  a_gpo_follow_reg: assert property (!cycling |=> gpo_q == $past(gpo_from_sw))
    else $error("general outputs do not follow switch register");
  a_gpo_count_cap: assert property (!DUAL_VARIANT |-> gpo_q[4] == 1'b0)
    else $error("fifth output driven on eight way variant");
  a_reset_defaults: assert property ($past(!reset_n) |-> sw_q == 8'h00 && err_en_q == 3'h6)
    else $error("wrong register value after reset");
  a_enable_off: assert property (!cycling && !sw_q[0] |=> !mux_enable)
    else $error("mux on while enable bit clear");
  a_pins_together: assert property (s_switch_write |=> chan_q == $past(chan_from_sw)
                                    && en_q == $past(sw_q[0]) && gpo_q == $past(gpo_from_sw))
    else $error("switch pins not updated together");
  a_flag_clear: assert property (clear_go |=> flags_q == 3'h0)
    else $error("error flags not cleared by command");
  a_flag_hold: assert property (flags_q != 3'h0 && !clear_go && !soft_q |=> flags_q != 3'h0)
    else $error("error flags lost without clear command");
  a_cycle_no_select: assert property (cycling && !soft_q |=> $stable(sw_q))
    else $error("switch register written in cycling mode");
  a_cycle_entry: assert property (cyc_en_q && mode_q == msg_pkg::MODE_ADDR && !soft_q
                                  |=> mode_q == msg_pkg::MODE_CYCLE)
    else $error("cycling enable did not enter cycling mode");

endmodule : msg_register_map
`default_nettype wire

// >>> msg_spi_host.sv
/*
  serial host model for the mux register map: mode 0 frames, msb first.
  assumes the bench owns clk and calls these tasks one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msg_register_map_map.svh"

module msg_spi_host (
  input  wire logic clk,   // bench clock
  output logic      cs_n,  // chip select to device
  output logic      sclk,  // serial clock, still between frames
  output logic      sdi,   // data to device
  input  wire logic sdo    // data from device
);
  int half = 4;  // clk periods per sclk phase, never below 3

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  task automatic hold_cs(input logic lvl);
    cs_n = lvl;
  endtask : hold_cs

  // ==================================================================
  // one 16-bit frame; rd collects the second byte seen on sdo
  task automatic xfer(input logic [15:0] cmd, output logic [7:0] rd);
    int i;
    rd   = 8'h00;
    cs_n = 1'b0;
    for (i = 15; i >= 0; i--)
    begin
      sdi = cmd[i];
      wait_clk(half);
      if (i < 8)
        rd[i] = sdo;
      sclk = 1'b1;
      wait_clk(half);
      sclk = 1'b0;
    end
    wait_clk(half);
    cs_n = 1'b1;
    sdi  = ~sdi;  // released line must not keep the last bit
    wait_clk(6);
  endtask : xfer

  // crc is kept disabled by the bench, so no crc byte follows
  task automatic clear_flags;
    logic [7:0] rd;
    xfer(`MSG_CMD_CLEAR, rd);
  endtask : clear_flags
endmodule : msg_spi_host
`default_nettype wire

// >>> mux_switch_gpo_register_map_tb_top.sv
/*
  self-checking bench for msg_register_map, 8:1 variant.
  assumes msg_spi_host drives the serial pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msg_register_map_map.svh"

module mux_switch_gpo_register_map_tb_top;
  logic       clk                 = 1'b0;
  logic       reset_n             = 1'b0;
  logic       convert_trigger_pin = 1'b0;
  logic       cs_n;
  logic       sclk;
  logic       sdi;
  logic       sdo;
  logic [4:0] general_output;
  logic [2:0] channel_select;
  logic       mux_enable;
  int         err_total   = 0;
  int         checks_done = 0;
  int         seed        = 34184;
  int         i;
  logic [7:0] sw_val      = 8'h00;
  logic [7:0] rd;

  always #2.5 clk = ~clk;

  msg_spi_host host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));

  msg_register_map #(.DUAL_VARIANT(1'b0)) dut_u (
    .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .convert_trigger_pin(convert_trigger_pin), .sdo(sdo),
    .general_output(general_output), .channel_select(channel_select),
    .mux_enable(mux_enable));

  // ==================================================================
  // expectations and compares
  function automatic logic [8:0] exp_pins(input logic [7:0] d);
    return {1'b0, d[7:4], d[3:1], d[0]};
  endfunction : exp_pins

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pins(input logic [8:0] exp);
    logic [8:0] got;
    got = {general_output, channel_select, mux_enable};
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: pins got %h expected %h", $time, got, exp);
    end
  endtask : chk_pins

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer({1'b0, a, d}, rd);
  endtask : wr_reg

  task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp);
    host_u.xfer({1'b1, a, 8'h00}, rd);
    chk_reg(rd, exp);
  endtask : rd_reg

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // ==================================================================
  // watchdog
  initial
  begin
    repeat (60000) @(posedge clk);
    err_total++;
    finish_test();
  end

  // ==================================================================
  // main sequence
  initial
  begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    chk_pins(9'h000);
    rd_reg(`MSG_OFS_SWITCH, 8'h00);
    rd_reg(`MSG_OFS_ERR_ENABLE, 8'h06);
    rd_reg(`MSG_OFS_CYCLE_SEL, 8'hff);
    rd_reg(`MSG_OFS_EDGE, 8'h00);
    rd_reg(`MSG_OFS_CYCLE_EN, 8'h00);
    for (i = 0; i < 12; i++)
    begin
      host_u.half = 3 + ($random(seed) & 3);
      sw_val = (i == 0) ? 8'hff : (i == 1) ? 8'hfe : (i == 2) ? 8'h01 : 8'($random(seed));
      wr_reg(`MSG_OFS_SWITCH, sw_val);
      chk_pins(exp_pins(sw_val));
      rd_reg(`MSG_OFS_SWITCH, sw_val);
    end
    // bad targets leave the switches alone and raise the address flag while the address check is enabled
    wr_reg(7'h04, 8'h55);
    chk_pins(exp_pins(sw_val));
    rd_reg(`MSG_OFS_ERR_FLAGS, 8'h04);
    host_u.clear_flags();
    rd_reg(`MSG_OFS_ERR_FLAGS, 8'h00);
    wr_reg(`MSG_OFS_ERR_FLAGS, 8'hff);
    rd_reg(`MSG_OFS_ERR_FLAGS, 8'h04);
    host_u.clear_flags();
    wr_reg(`MSG_OFS_ERR_ENABLE, 8'h02);
    wr_reg(7'h04, 8'h55);
    rd_reg(`MSG_OFS_ERR_FLAGS, 8'h00);
    wr_reg(`MSG_OFS_ERR_ENABLE, 8'h06);
    // cycling mode: outputs low, serial writes ignored, convert pin steps
    wr_reg(`MSG_OFS_CYCLE_EN, 8'h01);
    chk_pins(9'h001);
    wr_reg(`MSG_OFS_SWITCH, 8'hf0);
    chk_pins(9'h001);
    host_u.hold_cs(1'b0);
    repeat (4) @(negedge clk);
    convert_trigger_pin = 1'b1;
    repeat (8) @(negedge clk);
    chk_pins(9'h003);
    convert_trigger_pin = 1'b0;
    repeat (8) @(negedge clk);
    chk_pins(9'h003);
    host_u.hold_cs(1'b1);
    repeat (4) @(negedge clk);
    host_u.xfer(`MSG_CMD_EXIT_A, rd);
    host_u.xfer(`MSG_CMD_EXIT_B, rd);
    chk_pins(exp_pins(sw_val));
    // software restart, then a hardware reset in mid-run
    wr_reg(`MSG_OFS_ERR_ENABLE, 8'h02);
    wr_reg(`MSG_OFS_RESTART, `MSG_KEY_FIRST);
    wr_reg(`MSG_OFS_RESTART, `MSG_KEY_SECOND);
    chk_pins(9'h000);
    rd_reg(`MSG_OFS_ERR_ENABLE, 8'h06);
    wr_reg(`MSG_OFS_SWITCH, 8'haa);
    chk_pins(exp_pins(8'haa));
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    chk_pins(9'h000);
    rd_reg(`MSG_OFS_SWITCH, 8'h00);
    finish_test();
  end
endmodule : mux_switch_gpo_register_map_tb_top
`default_nettype wire
